// file: bench/qpfp_prog_model.sv
// Program memory and outside peripheral register model facing the core
`timescale 1ns/1ps
module qpfp_prog_model
    import qpfp_pkg::*;
(
    input wire logic [IMPL_ADDR_WIDTH-1:0] prog_addr,
    output logic [PROG_WORD_WIDTH-1:0] prog_word,
    input wire logic [7:0] periph_addr,
    output logic periph_hit,
    output logic [DATA_WIDTH-1:0] periph_rd_data
);
    localparam logic [6:0] PERIPH_OFS = 7'h01;
    localparam logic [7:0] PERIPH_VALUE = 8'hC6;
    // Each word carries its own address, so a wrong fetch shows at once
    assign prog_word = {3'b101, prog_addr};
    assign periph_hit = (periph_addr[6:0] == PERIPH_OFS);
    // A missing register drives a pattern, not zero, so an unmasked miss is caught
    assign periph_rd_data = periph_hit ? PERIPH_VALUE : ~periph_addr;
endmodule : qpfp_prog_model

// file: bench/test_quad_phase_fetch_pipeline_memmap.sv
// Self-checking bench for the quad-phase fetch pipeline and data-memory map
`timescale 1ns/1ps
module test_quad_phase_fetch_pipeline_memmap import qpfp_pkg::*;;
    logic sys_clk, sys_rst, int_req, phase_one, phase_two, phase_three, phase_four;
    logic exec_valid, periph_wr, periph_hit;
    qpfp_dmreq_type dm_req;
    qpfp_branch_type branch_req;
    logic [IMPL_ADDR_WIDTH-1:0] prog_addr;
    logic [PROG_WORD_WIDTH-1:0] prog_word, exec_word;
    logic [PC_WIDTH-1:0] program_counter;
    logic [7:0] dm_rd_data, periph_addr, periph_wdata, periph_rd_data, core_status, indirect_pointer;
    logic [4:0] pc_high_latch;
    int err_total, n_checks;

    qpfp_core qpfp_core_i (.sys_clk(sys_clk), .sys_rst(sys_rst), .phase_one(phase_one),
        .phase_two(phase_two), .phase_three(phase_three), .phase_four(phase_four), .prog_addr(prog_addr),
        .prog_word(prog_word), .exec_word(exec_word), .exec_valid(exec_valid),
        .program_counter(program_counter), .dm_req(dm_req), .branch_req(branch_req), .int_req(int_req),
        .dm_rd_data(dm_rd_data), .periph_addr(periph_addr), .periph_wr(periph_wr),
        .periph_wdata(periph_wdata), .periph_rd_data(periph_rd_data), .periph_hit(periph_hit),
        .core_status(core_status), .indirect_pointer(indirect_pointer), .pc_high_latch(pc_high_latch));

    qpfp_prog_model qpfp_prog_model_i (.prog_addr(prog_addr), .prog_word(prog_word),
        .periph_addr(periph_addr), .periph_hit(periph_hit), .periph_rd_data(periph_rd_data));

    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end

    function automatic logic [13:0] word_at(input logic [10:0] a);
        return {3'b101, a};
    endfunction : word_at

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_checks++;
        if (got !== exp) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    // One instruction cycle of decoder requests, held from phase one to the edge leaving phase four
    task automatic instr(input logic rd, input logic wr, input logic [6:0] a, input logic [7:0] d,
        input logic tk, input logic [12:0] tg, input logic irq);
        do @(negedge sys_clk); while (phase_four !== 1'b1);
        @(posedge sys_clk);
        dm_req <= '{rd: rd, wr: wr, addr: a, wdata: d};
        branch_req <= '{taken: tk, target: tg};
        int_req <= irq;
        repeat (4) @(posedge sys_clk);
        dm_req <= '0;
        branch_req <= '0;
        int_req <= 1'b0;
        @(negedge sys_clk);
    endtask : instr

    task automatic flush_chk(input logic [12:0] tg);
        int n;
        n = 0;
        @(negedge sys_clk);
        chk("exec_valid", 16'h0000, {15'h0000, exec_valid});
        chk("exec_word", {2'b00, NOP_WORD}, {2'b00, exec_word});
        chk("program_counter", {3'h0, tg + 13'h0001}, {3'h0, program_counter});
        chk("prog_addr", {5'h00, tg[10:0]}, {5'h00, prog_addr});
        while (exec_valid !== 1'b1 && n < 16) begin
            @(negedge sys_clk);
            n++;
        end
        chk("target word", {2'b00, word_at(tg[10:0])}, {2'b00, exec_word});
        repeat (4) @(negedge sys_clk);
        chk("next word", {2'b00, word_at(tg[10:0] + 11'h001)}, {2'b00, exec_word});
    endtask : flush_chk

    task automatic t_reset;
        chk("phase_one in reset", 16'h0001, {15'h0000, phase_one});
        chk("pc in reset", {3'h0, RESET_VECTOR}, {3'h0, program_counter});
        @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 8; i++) begin
            @(negedge sys_clk);
            chk("phases", {12'h000, 4'(1 << (i % 4))}, {12'h000, phase_four, phase_three, phase_two, phase_one});
            if (i == 3) chk("pc first", 16'h0001, {3'h0, program_counter});
            if (i == 5) chk("first word", {2'b00, word_at(11'h000)}, {2'b00, exec_word});
            if (i == 5) chk("first valid", 16'h0001, {15'h0000, exec_valid});
            if (i == 7) chk("pc second", 16'h0002, {3'h0, program_counter});
        end
        $display("reset test done");
    endtask : t_reset

    task automatic t_datamap;
        instr(1'b0, 1'b1, 7'h03, 8'h38, 1'b0, 13'h0000, 1'b0);
        chk("core_status", 16'h0038, {8'h00, core_status});
        chk("periph_wr on core write", 16'h0000, {15'h0000, periph_wr});
        instr(1'b0, 1'b1, 7'h04, 8'h25, 1'b0, 13'h0000, 1'b0);
        chk("indirect_pointer", 16'h0025, {8'h00, indirect_pointer});
        instr(1'b0, 1'b1, 7'h00, 8'h77, 1'b0, 13'h0000, 1'b0);
        instr(1'b0, 1'b1, 7'h70, 8'h5A, 1'b0, 13'h0000, 1'b0);
        instr(1'b0, 1'b1, 7'h03, 8'h18, 1'b0, 13'h0000, 1'b0);
        instr(1'b1, 1'b0, 7'h25, 8'h00, 1'b0, 13'h0000, 1'b0);
        chk("indirect target", 16'h0077, {8'h00, dm_rd_data});
        instr(1'b1, 1'b1, 7'h70, 8'hE1, 1'b0, 13'h0000, 1'b0);
        chk("common ram", 16'h005A, {8'h00, dm_rd_data});
        instr(1'b1, 1'b0, 7'h70, 8'h00, 1'b0, 13'h0000, 1'b0);
        chk("write after read", 16'h00E1, {8'h00, dm_rd_data});
        instr(1'b1, 1'b0, 7'h04, 8'h00, 1'b0, 13'h0000, 1'b0);
        chk("pointer mirror", 16'h0025, {8'h00, dm_rd_data});
        instr(1'b1, 1'b0, 7'h06, 8'h00, 1'b0, 13'h0000, 1'b0);
        chk("unimplemented", 16'h0000, {8'h00, dm_rd_data});
        instr(1'b1, 1'b0, 7'h01, 8'h00, 1'b0, 13'h0000, 1'b0);
        chk("peripheral", 16'h00C6, {8'h00, dm_rd_data});
        instr(1'b0, 1'b1, 7'h05, 8'hA5, 1'b0, 13'h0000, 1'b0);
        chk("periph_wr", 16'h0001, {15'h0000, periph_wr});
        chk("periph_addr", 16'h0005, {8'h00, periph_addr});
        chk("periph_wdata", 16'h00A5, {8'h00, periph_wdata});
        @(negedge sys_clk);
        chk("periph_wr pulse", 16'h0000, {15'h0000, periph_wr});
        instr(1'b0, 1'b1, 7'h03, 8'h38, 1'b0, 13'h0000, 1'b0);
        instr(1'b0, 1'b1, 7'h30, 8'h3C, 1'b0, 13'h0000, 1'b0);
        instr(1'b0, 1'b1, 7'h03, 8'h18, 1'b0, 13'h0000, 1'b0);
        instr(1'b0, 1'b1, 7'h30, 8'h0F, 1'b0, 13'h0000, 1'b0);
        instr(1'b1, 1'b0, 7'h30, 8'h00, 1'b0, 13'h0000, 1'b0);
        chk("lower bank ram", 16'h000F, {8'h00, dm_rd_data});
        instr(1'b0, 1'b1, 7'h04, 8'hB0, 1'b0, 13'h0000, 1'b0);
        instr(1'b1, 1'b0, 7'h00, 8'h00, 1'b0, 13'h0000, 1'b0);
        chk("indirect upper bank", 16'h003C, {8'h00, dm_rd_data});
        instr(1'b0, 1'b1, 7'h04, 8'h80, 1'b0, 13'h0000, 1'b0);
        instr(1'b1, 1'b0, 7'h00, 8'h00, 1'b0, 13'h0000, 1'b0);
        chk("self indirect", 16'h0000, {8'h00, dm_rd_data});
        $display("data map test done");
    endtask : t_datamap

    task automatic t_branch;
        instr(1'b0, 1'b0, 7'h00, 8'h00, 1'b1, 13'h1805, 1'b0);
        flush_chk(13'h1805);
        instr(1'b0, 1'b1, 7'h0A, 8'h1F, 1'b0, 13'h0000, 1'b0);
        chk("pc_high_latch", 16'h001F, {11'h000, pc_high_latch});
        instr(1'b0, 1'b1, 7'h02, 8'h10, 1'b0, 13'h0000, 1'b0);
        flush_chk(13'h1F10);
        instr(1'b0, 1'b0, 7'h00, 8'h00, 1'b0, 13'h0000, 1'b1);
        flush_chk(INT_VECTOR);
        instr(1'b0, 1'b0, 7'h00, 8'h00, 1'b1, 13'h0123, 1'b1);
        flush_chk(INT_VECTOR);
        $display("branch test done");
    endtask : t_branch

    task automatic print_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : print_verdict

    // Whole run needs well under 600 cycles; allow a wide margin
    initial begin
        #(2000 * 8);
        err_total++;
        print_verdict();
    end

    initial begin
        sys_rst = 1'b1;
        dm_req = '0;
        branch_req = '0;
        int_req = 1'b0;
        err_total = 0;
        n_checks = 0;
        repeat (20) @(posedge sys_clk);
        t_reset();
        t_datamap();
        t_branch();
        print_verdict();
    end
endmodule : test_quad_phase_fetch_pipeline_memmap

// file: src/qpfp_core.sv
// Quad-phase clock sequencer, two-stage fetch/execute pipeline and banked data-memory map
`timescale 1ns/1ps
module qpfp_core
    import qpfp_pkg::*;
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    output logic phase_one,
    output logic phase_two,
    output logic phase_three,
    output logic phase_four,
    output logic [IMPL_ADDR_WIDTH-1:0] prog_addr,
    input wire logic [PROG_WORD_WIDTH-1:0] prog_word,
    output logic [PROG_WORD_WIDTH-1:0] exec_word,
    output logic exec_valid,
    output logic [PC_WIDTH-1:0] program_counter,
    input wire qpfp_dmreq_type dm_req,
    input wire qpfp_branch_type branch_req,
    input wire logic int_req,
    output logic [DATA_WIDTH-1:0] dm_rd_data,
    output logic [7:0] periph_addr,
    output logic periph_wr,
    output logic [DATA_WIDTH-1:0] periph_wdata,
    input wire logic [DATA_WIDTH-1:0] periph_rd_data,
    input wire logic periph_hit,
    output logic [DATA_WIDTH-1:0] core_status,
    output logic [DATA_WIDTH-1:0] indirect_pointer,
    output logic [PC_HIGH_WIDTH-1:0] pc_high_latch
);

    qpfp_phase_type phase;
    qpfp_phase_type next_phase;
    logic [PC_WIDTH-1:0] pc;
    logic [PC_WIDTH-1:0] fetch_addr;
    logic [PROG_WORD_WIDTH-1:0] instruction_holding_register;
    logic holding_valid;
    logic redirect_pend;
    logic [PC_WIDTH-1:0] redirect_target;
    logic [DATA_WIDTH-1:0] ram [RAM_DEPTH];

    logic use_indirect;
    logic [7:0] eff_addr;
    logic [6:0] eff_low;
    logic eff_upper;
    logic ram_hit;
    logic [RAM_INDEX_WIDTH-1:0] ram_idx;
    logic self_indirect;
    logic [DATA_WIDTH-1:0] next_rd_data;
    logic wr_fire;
    logic rd_fire;
    logic pcl_write;

    // Phase sequencer: sys_clk is the oscillator, four edges per instruction cycle
    always_comb begin
        unique case (phase)
            PH_ONE: next_phase = PH_TWO;
            PH_TWO: next_phase = PH_THREE;
            PH_THREE: next_phase = PH_FOUR;
            PH_FOUR: next_phase = PH_ONE;
        endcase
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase <= PH_ONE;
        end else begin
            phase <= next_phase;
        end
    end

    // One-hot decode of a single state register cannot overlap
    assign phase_one = (phase == PH_ONE);
    assign phase_two = (phase == PH_TWO);
    assign phase_three = (phase == PH_THREE);
    assign phase_four = (phase == PH_FOUR);

    // Program counter and fetch address
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            pc <= RESET_VECTOR;
            fetch_addr <= RESET_VECTOR;
        end else if (phase == PH_ONE) begin
            if (redirect_pend) begin
                fetch_addr <= redirect_target;
                pc <= PC_WIDTH'(redirect_target + 13'h0001);
            end else begin
                fetch_addr <= pc;
                pc <= PC_WIDTH'(pc + 13'h0001);
            end
        end
    end

    // Upper two address bits are simply not wired to the 2K array, hence the wrap
    assign prog_addr = fetch_addr[IMPL_ADDR_WIDTH-1:0];
    assign program_counter = pc;

    // Fetch stage
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            instruction_holding_register <= NOP_WORD;
            holding_valid <= 1'b0;
        end else if (phase == PH_FOUR) begin
            instruction_holding_register <= prog_word;
            holding_valid <= 1'b1;
        end
    end

    // Execute stage: the word fetched last cycle runs while the next one is fetched
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            exec_word <= NOP_WORD;
            exec_valid <= 1'b0;
        end else if (phase == PH_ONE) begin
            if (redirect_pend) begin
                exec_word <= NOP_WORD;
                exec_valid <= 1'b0;
            end else begin
                exec_word <= instruction_holding_register;
                exec_valid <= holding_valid;
            end
        end
    end

    // Redirect is decided at the end of execution and applied at the next phase one.
    // Interrupt wins over a branch; no return address is saved.
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            redirect_pend <= 1'b0;
            redirect_target <= RESET_VECTOR;
        end else if (phase == PH_FOUR) begin
            redirect_pend <= int_req || (exec_valid && branch_req.taken) || pcl_write;
            if (int_req) begin
                redirect_target <= INT_VECTOR;
            end else if (exec_valid && branch_req.taken) begin
                redirect_target <= branch_req.target;
            end else begin
                redirect_target <= {pc_high_latch, dm_req.wdata};
            end
        end else if (phase == PH_ONE) begin
            redirect_pend <= 1'b0;
        end
    end

    // Address resolution: offset zero selects the indirect pointer as full address
    assign use_indirect = (dm_req.addr == OFS_INDIRECT_DATA_PORT);
    assign eff_addr = use_indirect ? indirect_pointer : {core_status[BANK_SELECT_POS], dm_req.addr};
    assign eff_low = eff_addr[6:0];
    assign eff_upper = eff_addr[7];
    assign self_indirect = (eff_low == OFS_INDIRECT_DATA_PORT);

    always_comb begin
        ram_hit = 1'b0;
        ram_idx = 8'h00;
        if (eff_low >= OFS_COMMON_BASE) begin
            ram_hit = 1'b1;
            ram_idx = {1'b0, eff_low - OFS_GPR_BASE};
        end else if (eff_low >= OFS_GPR_BASE) begin
            ram_hit = 1'b1;
            ram_idx = {1'b0, eff_low - OFS_GPR_BASE};
            // Upper bank bytes follow the 96 lower ones in the same array
            if (eff_upper) begin
                ram_idx = 8'(ram_idx + BANK1_RAM_OFFSET);
            end
        end
    end

    // Flushed slots are gated off so they touch nothing
    assign rd_fire = (phase == PH_TWO) && exec_valid && dm_req.rd;
    assign wr_fire = (phase == PH_FOUR) && exec_valid && dm_req.wr;
    assign pcl_write = wr_fire && (eff_low == OFS_PROGRAM_COUNTER_LOW);

    // Core registers decode on the low seven bits only, so both banks share them
    always_comb begin
        next_rd_data = RESET_READ_DATA;
        if (ram_hit) begin
            next_rd_data = ram[ram_idx];
        end else begin
            unique case (eff_low)
                OFS_INDIRECT_DATA_PORT: next_rd_data = RESET_READ_DATA;
                OFS_PROGRAM_COUNTER_LOW: next_rd_data = pc[7:0];
                OFS_CORE_STATUS: next_rd_data = core_status;
                OFS_INDIRECT_POINTER: next_rd_data = indirect_pointer;
                OFS_PC_HIGH_LATCH: next_rd_data = {3'b000, pc_high_latch};
                default: next_rd_data = periph_hit ? periph_rd_data : RESET_READ_DATA;
            endcase
        end
    end

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            dm_rd_data <= RESET_READ_DATA;
        end else if (rd_fire) begin
            dm_rd_data <= next_rd_data;
        end
    end

    // Core register writes in phase four
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            core_status <= RESET_CORE_STATUS;
            indirect_pointer <= RESET_INDIRECT_POINTER;
            pc_high_latch <= RESET_PC_HIGH_LATCH;
        end else if (wr_fire && !ram_hit) begin
            if (eff_low == OFS_CORE_STATUS) begin
                core_status <= dm_req.wdata;
            end
            if (eff_low == OFS_INDIRECT_POINTER) begin
                indirect_pointer <= dm_req.wdata;
            end
            if (eff_low == OFS_PC_HIGH_LATCH) begin
                pc_high_latch <= dm_req.wdata[PC_HIGH_WIDTH-1:0];
            end
        end
    end

    // General purpose RAM carries no reset, as static RAM would not
    always_ff @(posedge sys_clk) begin
        if (wr_fire && ram_hit) begin
            ram[ram_idx] <= dm_req.wdata;
        end
    end

    // Peripheral register space, banked, low addresses other than the core set
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            periph_addr <= 8'h00;
            periph_wr <= 1'b0;
            periph_wdata <= 8'h00;
        end else begin
            periph_addr <= eff_addr;
            periph_wr <= wr_fire && !ram_hit && !self_indirect
                && (eff_low != OFS_PROGRAM_COUNTER_LOW) && (eff_low != OFS_CORE_STATUS)
                && (eff_low != OFS_INDIRECT_POINTER) && (eff_low != OFS_PC_HIGH_LATCH);
            periph_wdata <= dm_req.wdata;
        end
    end

    default clocking qpfp_cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    sequence s_rest_of_cycle;
        (phase == PH_TWO) ##1 (phase == PH_THREE) ##1 (phase == PH_FOUR) ##1 (phase == PH_ONE);
    endsequence

    sequence s_flushed_cycle;
        !exec_valid && (exec_word == NOP_WORD) ##1 (!exec_valid && !wr_fire && !rd_fire) [*3];
    endsequence

    a_phase_rotation: assert property ((phase == PH_ONE) |=> s_rest_of_cycle)
        else $error("phase sequence did not rotate through four phases");

    a_phase_one_hot: assert property ($onehot({phase_one, phase_two, phase_three, phase_four}))
        else $error("phase outputs overlap or vanish");

    a_pc_step: assert property ((phase == PH_ONE) && !redirect_pend |=> pc == PC_WIDTH'($past(pc) + 13'h0001))
        else $error("program counter did not step by one in phase one");

    a_pc_hold: assert property ((phase != PH_ONE) |=> $stable(pc))
        else $error("program counter moved outside phase one");

    a_fetch_capture: assert property ((phase == PH_FOUR) |=> instruction_holding_register == $past(prog_word))
        else $error("holding register missed the phase four fetch");

    a_exec_load: assert property ((phase == PH_ONE) && !redirect_pend && holding_valid
        |=> (exec_word == $past(instruction_holding_register)) && exec_valid)
        else $error("fetched word not moved to execute stage");

    a_flush_nop: assert property ((phase == PH_ONE) && redirect_pend |=> s_flushed_cycle)
        else $error("discarded instruction was not turned into a no-operation");

    a_branch_target: assert property ((phase == PH_FOUR) && exec_valid && branch_req.taken && !int_req
        |=> ##1 fetch_addr == $past(branch_req.target, 2))
        else $error("branch target not fetched in the next cycle");

    a_int_vector: assert property ((phase == PH_FOUR) && int_req |=> ##1 fetch_addr == INT_VECTOR)
        else $error("interrupt did not vector to address four");

    a_prog_wrap: assert property ((phase == PH_ONE) && !redirect_pend
        |=> prog_addr == IMPL_ADDR_WIDTH'($past(pc)))
        else $error("program address does not wrap onto the implemented words");

    a_status_write: assert property (wr_fire && (eff_low == OFS_CORE_STATUS) && !ram_hit
        |=> core_status == $past(dm_req.wdata))
        else $error("core status write lost");

    a_common_alias: assert property (ram_hit && (eff_low >= OFS_COMMON_BASE)
        |-> ram_idx < BANK1_RAM_OFFSET)
        else $error("common window maps outside the lower bank");

    a_upper_bank: assert property (ram_hit && eff_upper && (eff_low < OFS_COMMON_BASE)
        |-> ram_idx >= BANK1_RAM_OFFSET)
        else $error("upper bank storage overlaps the lower bank");

    a_unimpl_zero: assert property (rd_fire && !ram_hit && !periph_hit
        && (eff_low != OFS_PROGRAM_COUNTER_LOW) && (eff_low != OFS_CORE_STATUS)
        && (eff_low != OFS_INDIRECT_POINTER) && (eff_low != OFS_PC_HIGH_LATCH)
        |=> dm_rd_data == RESET_READ_DATA)
        else $error("unimplemented location did not read as zero");

    a_core_mirror: assert property (rd_fire && (eff_low == OFS_INDIRECT_POINTER)
        |=> dm_rd_data == $past(indirect_pointer))
        else $error("pointer read differs between banks");

    // Each storage class may only move on the edge that its phase owns
    a_read_phase: assert property ((phase != PH_TWO) |=> $stable(dm_rd_data))
        else $error("operand read outside phase two");

    a_write_phase: assert property ((phase != PH_FOUR)
        |=> $stable(core_status) && $stable(indirect_pointer) && $stable(pc_high_latch))
        else $error("core register written outside phase four");

    a_holding_hold: assert property ((phase != PH_FOUR) |=> $stable(instruction_holding_register))
        else $error("holding register changed outside phase four");

    a_exec_hold: assert property ((phase != PH_ONE) |=> $stable(exec_word) && $stable(exec_valid))
        else $error("instruction register changed outside phase one");

    a_flush_quiet: assert property (!exec_valid |=> !periph_wr)
        else $error("flushed slot wrote a peripheral register");

    a_pcl_jump: assert property ((phase == PH_FOUR) && pcl_write && !int_req && !branch_req.taken
        |=> ##1 fetch_addr == {$past(pc_high_latch, 2), $past(dm_req.wdata, 2)})
        else $error("program counter low write did not redirect the fetch");

endmodule : qpfp_core

// file: src/qpfp_pkg.sv
// Constants, carriers and phase encoding for the quad-phase fetch pipeline and data-memory map
package qpfp_pkg;

    localparam int PC_WIDTH = 13;
    localparam int PROG_WORD_WIDTH = 14;
    localparam int IMPL_ADDR_WIDTH = 11;
    localparam int DATA_WIDTH = 8;
    localparam int RAM_INDEX_WIDTH = 8;

    localparam logic [12:0] RESET_VECTOR = 13'h0000;
    localparam logic [12:0] INT_VECTOR = 13'h0004;
    localparam logic [13:0] NOP_WORD = 14'h0000;

    // Register offsets within a bank (low seven address bits)
    localparam logic [6:0] OFS_INDIRECT_DATA_PORT = 7'h00;
    localparam logic [6:0] OFS_PROGRAM_COUNTER_LOW = 7'h02;
    localparam logic [6:0] OFS_CORE_STATUS = 7'h03;
    localparam logic [6:0] OFS_INDIRECT_POINTER = 7'h04;
    localparam logic [6:0] OFS_PC_HIGH_LATCH = 7'h0A;
    localparam logic [6:0] OFS_SFR_TOP = 7'h1F;
    localparam logic [6:0] OFS_GPR_BASE = 7'h20;
    localparam logic [6:0] OFS_COMMON_BASE = 7'h70;

    localparam int BANK_SELECT_POS = 5;
    localparam int PC_HIGH_WIDTH = 5;

    // Lower bank holds 96 bytes (20h-7Fh), upper bank 80 bytes (A0h-EFh)
    localparam logic [7:0] BANK1_RAM_OFFSET = 8'h60;
    localparam int RAM_DEPTH = 176;

    localparam logic [7:0] RESET_CORE_STATUS = 8'h18;
    localparam logic [7:0] RESET_INDIRECT_POINTER = 8'h00;
    localparam logic [4:0] RESET_PC_HIGH_LATCH = 5'h00;
    localparam logic [7:0] RESET_READ_DATA = 8'h00;

    typedef enum logic [1:0] {
        PH_ONE,
        PH_TWO,
        PH_THREE,
        PH_FOUR
    } qpfp_phase_type;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [6:0] addr;
        logic [7:0] wdata;
    } qpfp_dmreq_type;

    typedef struct packed {
        logic taken;
        logic [12:0] target;
    } qpfp_branch_type;

endpackage : qpfp_pkg
